// file: verilog/smc_cfg_pkg.sv
// constants and types for the static memory timing configuration block
//
// Contract
// - capability bits 5..4 read 01, a 16-bit widest external data bus.
// - capability bits 3..2 give supported area count minus one; four areas here.
// - capability bits 1..0 read 11 whenever multiplexed bus mode is set.
// - command bits 25..23 pick area 0..3; codes 4..7 are never written.
// - command type bits 22..21 must be 10, meaning apply staged values.
// - staged timings do not touch accesses until the update command arrives.
// - staging bits 19..17 hold turnaround, one to seven clocks, zero forbidden.
// - staging bits 16..14 hold page cycle, ignored in multiplexed mode.
// - staging bits 13..11 hold write pulse, stretched one clock in multiplexed mode.
// - staging bits 10..8 hold output-enable delay, one to seven clocks.
// - staging bits 7..4 hold write cycle, three to fifteen clocks.
// - staging bits 3..0 hold read cycle, two to fifteen clocks.
// - all counts are in controller clock periods, half the system clock.
// - staged mode settings also take effect only on the update command.
// - mode register bit 0 selects multiplexed bus; not changed while active.
package smc_cfg_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [11:0] CAPABILITY_OFF = 12'h004;
  localparam logic [11:0] DIRECT_CMD_OFF = 12'h010;
  localparam logic [11:0] CYCLES_STAGE_OFF = 12'h014;
  localparam logic [11:0] OPMODE_STAGE_OFF = 12'h018;
  localparam logic [11:0] MODE_OFF = 12'h01C;

  // ==========================================================
  // capability fields
  localparam logic [1:0] CAP_WIDTH_16 = 2'h1;
  localparam logic [1:0] CAP_FOUR_AREAS = 2'h3;
  localparam logic [1:0] CAP_TYPE_SRAM_MUX = 2'h3;
  localparam logic [1:0] CAP_TYPE_OTHER = 2'h0;
  localparam int CAP_WIDTH_LSB = 4;
  localparam int CAP_CHIPS_LSB = 2;

  // ==========================================================
  // direct command fields
  localparam int CMD_CS_LSB = 23;
  localparam int CMD_TYPE_LSB = 21;
  localparam logic [1:0] CMD_UPDATE = 2'h2;
  localparam logic [2:0] CMD_CS_LAST = 3'h3;

  // ==========================================================
  // staging timing fields, width 20
  localparam int TURN_LSB = 17;
  localparam int PAGE_LSB = 14;
  localparam int WPULSE_LSB = 11;
  localparam int OEDLY_LSB = 8;
  localparam int WCYC_LSB = 4;
  localparam int RCYC_LSB = 0;
  localparam logic [19:0] CYCLES_MASK = 20'hFFFFF;
  localparam logic [19:0] CYCLES_RST = 20'h2B3C2;

  // ==========================================================
  // staging mode fields: latch enable bit 11, burst 5..3, width 1..0
  localparam logic [11:0] OPMODE_MASK = 12'h83B;
  localparam logic [11:0] OPMODE_RST = 12'h801;
  localparam logic MODE_RST = 1'b0;

  // bus handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_st_e;
endpackage

// file: verilog/smc_timing_cfg.sv
// register file and active timing store of the static memory controller
`timescale 1ns/1ps
`default_nettype none
module smc_timing_cfg (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic mux_mode_o,
  output logic ctrl_clock_o,
  output logic update_done_o,
  output logic [3:0][19:0] area_cycles_o,
  output logic [3:0][11:0] area_opmode_o,
  output logic [3:0][3:0] write_pulse_count_o,
  output logic [3:0][2:0] page_cycle_count_o
);

  // ==========================================================
  // state
  typedef struct packed {
    smc_cfg_pkg::bus_st_e bus;
    logic [31:0] rdata;
    logic mux;
    logic ctrl_clock;
    logic upd;
    logic [19:0] stage_cycles;
    logic [11:0] stage_opmode;
    logic [3:0][19:0] act_cycles;
    logic [3:0][11:0] act_opmode;
    logic [3:0][3:0] eff_wp;
    logic [3:0][2:0] eff_pc;
  } state_s;

  state_s st;
  state_s next_st;

  // byte lane merge for a masked word
  function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] din,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = din[b*8 +: 8];
      end
    end
    return res;
  endfunction

  logic req;
  logic commit;
  logic hit_cap;
  logic hit_cmd;
  logic hit_cyc;
  logic hit_opm;
  logic hit_mode;
  logic [31:0] cmd_word;
  logic [2:0] cmd_cs;
  logic [1:0] cmd_kind;
  logic [31:0] cyc_merge;
  logic [31:0] opm_merge;

  // ==========================================================
  // decode; only the word index matters, low address bits ignored
  assign req = wb_cyc_i & wb_stb_i;
  assign hit_cap = wb_adr_i[11:2] == smc_cfg_pkg::CAPABILITY_OFF[11:2];
  assign hit_cmd = wb_adr_i[11:2] == smc_cfg_pkg::DIRECT_CMD_OFF[11:2];
  assign hit_cyc = wb_adr_i[11:2] == smc_cfg_pkg::CYCLES_STAGE_OFF[11:2];
  assign hit_opm = wb_adr_i[11:2] == smc_cfg_pkg::OPMODE_STAGE_OFF[11:2];
  assign hit_mode = wb_adr_i[11:2] == smc_cfg_pkg::MODE_OFF[11:2];
  // writes land on the edge where the master sees ack
  assign commit = req & wb_we_i & (st.bus == smc_cfg_pkg::BUS_ACK);
  assign cmd_word = lanes(32'h00000000, wb_dat_i, wb_sel_i);
  assign cmd_cs = cmd_word[smc_cfg_pkg::CMD_CS_LSB +: 3];
  assign cmd_kind = cmd_word[smc_cfg_pkg::CMD_TYPE_LSB +: 2];
  // lane-merged staging words, sliced and masked in the write logic below
  assign cyc_merge = lanes({12'h000, st.stage_cycles}, wb_dat_i, wb_sel_i);
  assign opm_merge = lanes({20'h00000, st.stage_opmode}, wb_dat_i, wb_sel_i);

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    next_st.upd = 1'b0;
    // controller clock is half the system clock; counts are in its periods
    next_st.ctrl_clock = ~st.ctrl_clock;

    // bus handshake: ack one cycle after request, dropped the cycle after
    case (st.bus)
      smc_cfg_pkg::BUS_IDLE: begin
        if (req) begin
          next_st.bus = smc_cfg_pkg::BUS_ACK;
          next_st.rdata = 32'h00000000;
          if (hit_cap) begin
            // reserved high bits chosen to read zero
            next_st.rdata[smc_cfg_pkg::CAP_WIDTH_LSB +: 2] = smc_cfg_pkg::CAP_WIDTH_16;
            next_st.rdata[smc_cfg_pkg::CAP_CHIPS_LSB +: 2] = smc_cfg_pkg::CAP_FOUR_AREAS;
            next_st.rdata[1:0] = st.mux ? smc_cfg_pkg::CAP_TYPE_SRAM_MUX
                                        : smc_cfg_pkg::CAP_TYPE_OTHER;
          end else if (hit_mode) begin
            next_st.rdata[0] = st.mux;
          end
        end
      end
      smc_cfg_pkg::BUS_ACK: begin
        next_st.bus = smc_cfg_pkg::BUS_IDLE;
      end
      default: begin
        next_st.bus = smc_cfg_pkg::BUS_IDLE;
      end
    endcase

    // register writes; reserved bits are masked off
    if (commit) begin
      if (hit_cyc) begin
        // staging only; no active timing moves here
        next_st.stage_cycles = cyc_merge[19:0] & smc_cfg_pkg::CYCLES_MASK;
      end
      if (hit_opm) begin
        next_st.stage_opmode = opm_merge[11:0] & smc_cfg_pkg::OPMODE_MASK;
      end
      if (hit_mode && wb_sel_i[0]) begin
        // changing this while accesses run is the software's fault
        next_st.mux = wb_dat_i[0];
      end
      // unsupported areas and command kinds are dropped silently
      if (hit_cmd && cmd_kind == smc_cfg_pkg::CMD_UPDATE
          && cmd_cs <= smc_cfg_pkg::CMD_CS_LAST) begin
        next_st.act_cycles[cmd_cs[1:0]] = st.stage_cycles;
        next_st.act_opmode[cmd_cs[1:0]] = st.stage_opmode;
        next_st.upd = 1'b1;
      end
    end

    // derived per-area counts track both the active timings and the bus mode
    for (int a = 0; a < 4; a++) begin
      // one extra write pulse clock in multiplexed mode
      next_st.eff_wp[a] = {1'b0, next_st.act_cycles[a][smc_cfg_pkg::WPULSE_LSB +: 3]}
                          + {3'h0, next_st.mux};
      // no page access on the multiplexed bus
      next_st.eff_pc[a] = next_st.mux ? 3'h0
                          : next_st.act_cycles[a][smc_cfg_pkg::PAGE_LSB +: 3];
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st.bus <= smc_cfg_pkg::BUS_IDLE;
      st.rdata <= 32'h00000000;
      st.mux <= smc_cfg_pkg::MODE_RST;
      st.ctrl_clock <= 1'b0;
      st.upd <= 1'b0;
      st.stage_cycles <= smc_cfg_pkg::CYCLES_RST;
      st.stage_opmode <= smc_cfg_pkg::OPMODE_RST;
      for (int a = 0; a < 4; a++) begin
        st.act_cycles[a] <= smc_cfg_pkg::CYCLES_RST;
        st.act_opmode[a] <= smc_cfg_pkg::OPMODE_RST;
        st.eff_wp[a] <= {1'b0, smc_cfg_pkg::CYCLES_RST[smc_cfg_pkg::WPULSE_LSB +: 3]};
        st.eff_pc[a] <= smc_cfg_pkg::CYCLES_RST[smc_cfg_pkg::PAGE_LSB +: 3];
      end
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs, each straight from the state register
  assign wb_ack_o = st.bus[1]; // one-hot ack state bit
  assign wb_dat_o = st.rdata;
  assign mux_mode_o = st.mux;
  assign ctrl_clock_o = st.ctrl_clock;
  assign update_done_o = st.upd;
  // field positions of the active word follow the staging layout
  assign area_cycles_o = st.act_cycles;
  assign area_opmode_o = st.act_opmode;
  assign write_pulse_count_o = st.eff_wp;
  assign page_cycle_count_o = st.eff_pc;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence seq_cap_read;
    req && !wb_we_i && hit_cap && st.bus == smc_cfg_pkg::BUS_IDLE;
  endsequence

  sequence seq_update(logic [2:0] cs);
    commit && hit_cmd && cmd_kind == smc_cfg_pkg::CMD_UPDATE && cmd_cs == cs;
  endsequence

  sequence seq_stage_write;
    commit && hit_cyc && !hit_cmd;
  endsequence

  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty

  AST_ACK_PULSE: assert property (p_ack_pulse)
    else $error("ack stayed high two cycles");

  AST_ACK_FOLLOWS: assert property (req && st.bus == smc_cfg_pkg::BUS_IDLE |=> wb_ack_o)
    else $error("ack missing one cycle after request");

  AST_CAP_WIDTH: assert property (seq_cap_read |=> wb_dat_o[5:4] == 2'h1)
    else $error("capability width code wrong");

  AST_CAP_CHIPS: assert property (seq_cap_read |=> wb_dat_o[3:2] == 2'h3)
    else $error("capability area count wrong");

  AST_CAP_TYPE: assert property (seq_cap_read ##0 mux_mode_o |=> wb_dat_o[1:0] == 2'h3)
    else $error("memory type not 11 in multiplexed mode");

  AST_BAD_AREA: assert property (commit && hit_cmd && cmd_cs[2] |=> $stable(area_cycles_o))
    else $error("invalid area code changed active timings");

  AST_BAD_KIND: assert property (commit && hit_cmd && cmd_kind != 2'h2
                                 |=> $stable(area_cycles_o) && !update_done_o)
    else $error("invalid command kind acted");

  AST_STAGE_HOLD: assert property (seq_stage_write
                                   |=> $stable(area_cycles_o) && $stable(area_opmode_o))
    else $error("staging write reached active timings");

  AST_UPDATE_COPY: assert property (seq_update(3'h2) |=> update_done_o
                                    && area_cycles_o[2] == $past(st.stage_cycles)
                                    && $stable(area_cycles_o[0]))
    else $error("update did not copy staged timings to area two");

  AST_OPMODE_COPY: assert property (seq_update(3'h3)
                                    |=> area_opmode_o[3] == $past(st.stage_opmode))
    else $error("update did not copy staged mode to area three");

  AST_WP_STRETCH: assert property (mux_mode_o |-> write_pulse_count_o[3]
                                   == {1'b0, area_cycles_o[3][13:11]} + 4'h1)
    else $error("write pulse not stretched in multiplexed mode");

  AST_PAGE_IGNORED: assert property (mux_mode_o |-> page_cycle_count_o[0] == 3'h0)
    else $error("page cycle used in multiplexed mode");

  AST_CTRL_HALF: assert property (ctrl_clock_o |=> !ctrl_clock_o ##1 ctrl_clock_o)
    else $error("controller clock not half rate");

  AST_MODE_WRITE: assert property (commit && hit_mode && wb_sel_i[0]
                                   |=> mux_mode_o == $past(wb_dat_i[0]))
    else $error("mode bit not written");

  // ==========================================================
  // bus handshake checks
  sequence seq_wo_read;
    req && !wb_we_i && (hit_cyc || hit_cmd || hit_opm) && st.bus == smc_cfg_pkg::BUS_IDLE;
  endsequence

  // no request, no answer; a stray ack would retire a master early
  AST_ACK_QUIET: assert property (!req && !wb_ack_o |=> !wb_ack_o)
    else $error("ack without a request");

  // read data stands until the next request is taken
  AST_RDATA_HOLD: assert property (!(req && st.bus == smc_cfg_pkg::BUS_IDLE)
                                   |=> $stable(wb_dat_o))
    else $error("read data moved without a new request");

  // update flag is a single-cycle strobe
  AST_UPD_PULSE: assert property (update_done_o |=> !update_done_o)
    else $error("update flag held two cycles");

  // the strobe only follows an accepted update command
  AST_UPD_SOURCE: assert property (update_done_o |-> $past(commit && hit_cmd
                                   && cmd_kind == smc_cfg_pkg::CMD_UPDATE && !cmd_cs[2]))
    else $error("update flag without an update command");

  // ==========================================================
  // capability and read-back checks
  // reserved high bits are fixed at zero here
  AST_CAP_RSVD: assert property (seq_cap_read |=> wb_dat_o[31:6] == 26'h0)
    else $error("capability reserved bits not zero");

  // separate bus reports no memory type code
  AST_CAP_TYPE_SEP: assert property (seq_cap_read ##0 !mux_mode_o
                                     |=> wb_dat_o[1:0] == 2'h0)
    else $error("memory type not 00 on the separate bus");

  // staging and command registers are write-only and read as zero
  AST_WO_READ: assert property (seq_wo_read |=> wb_dat_o == 32'h00000000)
    else $error("write-only register read back nonzero");

  // ==========================================================
  // active timing checks
  // active words move only on a command write
  AST_AREA_STEADY: assert property (!(commit && hit_cmd)
                                    |=> $stable(area_cycles_o) && $stable(area_opmode_o))
    else $error("active timings moved without a command");

  // a full-lane staging write lands whole in the staging word
  AST_STAGE_TAKE: assert property (seq_stage_write ##0 wb_sel_i == 4'hF
                                   |=> st.stage_cycles == $past(wb_dat_i[19:0]))
    else $error("staging write not captured");

  // an update to area two leaves the other areas' timings and area three's mode alone
  AST_OTHER_AREAS: assert property (seq_update(3'h2) |=> $stable(area_cycles_o[0])
                                    && $stable(area_cycles_o[1]) && $stable(area_cycles_o[3])
                                    && $stable(area_opmode_o[3]))
    else $error("update to area two touched another area");

  // an update to area three leaves area zero's mode alone
  AST_AREA3_ONLY: assert property (seq_update(3'h3) |=> $stable(area_opmode_o[0])
                                   && $stable(area_cycles_o[2]))
    else $error("update to area three touched another area");

  // an illegal area code never acts, on either active word
  AST_BAD_AREA_OPM: assert property (commit && hit_cmd && cmd_cs[2]
                                     |=> $stable(area_opmode_o) && !update_done_o)
    else $error("invalid area code changed active mode");

  // ==========================================================
  // derived count checks
  // separate bus uses the programmed write pulse as it stands
  AST_WP_PLAIN: assert property (!mux_mode_o |-> write_pulse_count_o[0]
                                 == {1'b0, area_cycles_o[0][13:11]})
    else $error("write pulse stretched on the separate bus");

  // separate bus passes the page cycle through
  AST_PAGE_SEP: assert property (!mux_mode_o |-> page_cycle_count_o[1]
                                 == area_cycles_o[1][16:14])
    else $error("page cycle lost on the separate bus");

  // controller clock never rests low two cycles in a row
  AST_CTRL_RISE: assert property (!ctrl_clock_o |=> ctrl_clock_o)
    else $error("controller clock stuck low");

  // the bus mode bit only moves on a write of its own lane
  AST_MODE_HOLD: assert property (!(commit && hit_mode && wb_sel_i[0])
                                  |=> $stable(mux_mode_o))
    else $error("bus mode bit moved without a write");

endmodule
`default_nettype wire

// file: dv/mem_clk_model.sv
// far-side memory model: counts controller clock rises it receives
`timescale 1ns/1ps
`default_nettype none
module mem_clk_model (
  input wire logic clk_i,
  input wire logic ctrl_clock_i,
  output int rises_o
);
  logic prev = 1'b0;
  int cnt = 0;
  // ==========================================================
  // edge counter, sampled on the system clock like the real pins
  // memory only sees rising controller edges, half the system rate
  always @(posedge clk_i) begin
    if (ctrl_clock_i && !prev) cnt <= cnt + 1;
    prev <= ctrl_clock_i;
  end
  assign rises_o = cnt;
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// testbench for the static memory timing configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i, rst_i, cyc, stb, we, ack, mux, cclk, upd;
  logic [11:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, got;
  logic [3:0][19:0] cyc_a;
  logic [3:0][11:0] op_a;
  logic [3:0][3:0] wp_a;
  logic [3:0][2:0] pg_a;
  int err_total = 0;
  int checks = 0;
  int upd_n = 0;
  int rises;
  int r0;
  localparam logic [19:0] STG = 20'hEF2F5;

  smc_timing_cfg u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .mux_mode_o(mux), .ctrl_clock_o(cclk), .update_done_o(upd),
    .area_cycles_o(cyc_a), .area_opmode_o(op_a), .write_pulse_count_o(wp_a),
    .page_cycle_count_o(pg_a));
  mem_clk_model u_mem (.clk_i(clk_i), .ctrl_clock_i(cclk), .rises_o(rises));

  // ==========================================================
  // clock, update pulse counter and watchdog
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (upd === 1'b1) upd_n++;
  initial begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    test_done;
  end

  // ==========================================================
  // compare, bus cycle and closing tasks
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // classic cycle: hold until ack is sampled, then idle so outputs settle
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    // no local limit: only the watchdog ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    got = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==========================================================
  // test sequence
  initial begin
    rst_i <= 1'b1;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    adr <= 12'h000;
    wdat <= 32'h00000000;
    sel <= 4'hF;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, 12'h004, 32'h0);
    chk("cap_sep", 32'h0000001C, got);
    bus(1'b1, 12'h01C, 32'h00000001);
    bus(1'b0, 12'h004, 32'h0);
    chk("cap_mux", 32'h0000001F, got);
    chk("mux", 32'h1, {31'h0, mux});
    $display("test capability done");
    bus(1'b1, 12'h014, {12'h000, STG});
    chk("staged_idle", 32'h0002B3C2, {12'h0, cyc_a[2]});
    bus(1'b1, 12'h010, 32'h01400000);
    chk("area2", {12'h0, STG}, {12'h0, cyc_a[2]});
    chk("area1", 32'h0002B3C2, {12'h0, cyc_a[1]});
    chk("wp_mux", 32'h7, {28'h0, wp_a[2]});
    chk("pg_mux", 32'h0, {29'h0, pg_a[2]});
    // every prohibited select and command type must leave area 0 alone
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 12'h010, {6'h00, 3'(4 + i), 2'h2, 21'h000000});
      if (i != 2) bus(1'b1, 12'h010, {6'h00, 3'h0, 2'(i), 21'h000000});
    end
    chk("area0", 32'h0002B3C2, {12'h0, cyc_a[0]});
    chk("area1_kept", 32'h0002B3C2, {12'h0, cyc_a[1]});
    chk("area3_kept", 32'h0002B3C2, {12'h0, cyc_a[3]});
    bus(1'b1, 12'h01C, 32'h0);
    chk("wp_sep", 32'h6, {28'h0, wp_a[2]});
    chk("pg_sep", 32'h3, {29'h0, pg_a[2]});
    $display("test cycles update done");
    bus(1'b1, 12'h018, 32'h00000809);
    chk("opmode_idle", 32'h801, {20'h0, op_a[3]});
    bus(1'b1, 12'h010, 32'h01C00000);
    chk("opmode3", 32'h809, {20'h0, op_a[3]});
    chk("area3", {12'h0, STG}, {12'h0, cyc_a[3]});
    chk("opmode0", 32'h801, {20'h0, op_a[0]});
    chk("upd_pulses", 32'h2, 32'(upd_n));
    bus(1'b0, 12'h014, 32'h0);
    chk("wo_read", 32'h0, got);
    bus(1'b0, 12'h020, 32'h0);
    chk("unmapped", 32'h0, got);
    $display("test opmode and refusals done");
    r0 = rises;
    repeat (40) @(posedge clk_i);
    // let the model's count from the last edge settle before reading it
    #1;
    chk("ctrl_clock", 32'h14, 32'(rises - r0));
    $display("test controller clock done");
    test_done;
  end
endmodule
`default_nettype wire
